// file: cfs_pkg.sv
/*
 Constants for the converter fault supervisor: timing, telemetry slots,
 response codes, status bit positions and controller states.
 Assumes a 50 MHz system clock.
*/
`default_nettype none
package cfs_pkg;
	localparam int CLK_NS          = 20;
	localparam int CONV_TIME_NS    = 500000;
	localparam int REFRESH_TIME_NS = 2000000;
	localparam int CONV_CYC        = CONV_TIME_NS / CLK_NS;
	localparam int ADC_SLOTS       = REFRESH_TIME_NS / CONV_TIME_NS;
	localparam logic [1:0] Q_VIN  = 2'h0;
	localparam logic [1:0] Q_VOUT = 2'h1;
	localparam logic [1:0] Q_IOUT = 2'h2;
	localparam logic [1:0] Q_TEMP = 2'h3;
	localparam logic [2:0] AVG_MAX_LOG2 = 3'h4;
	localparam logic [1:0] RESP_SHUT    = 2'h0;
	localparam logic [1:0] RESP_RESTART = 2'h1;
	localparam int DISCH_MV    = 200;
	localparam int VOUT_LSB_MV = 1;
	localparam int DISCH_CODE  = DISCH_MV / VOUT_LSB_MV;
	localparam int SCALE_FRAC  = 8;
	localparam int ST_OCW = 0;
	localparam int ST_OCF = 1;
	localparam int ST_OVF = 2;
	localparam int ST_UVF = 3;
	localparam int ST_OTW = 4;
	localparam int ST_OTF = 5;
	localparam int ST_TSD = 6;
	localparam int ST_CTO = 7;
	typedef enum logic [1:0] {
		CFS_RUN     = 2'h0,
		CFS_DISCH   = 2'h1,
		CFS_OFF     = 2'h3,
		CFS_RESTART = 2'h2
	} cfs_state_t;
endpackage
`default_nettype wire

// file: cfs_supervisor.sv
/*
 Fault supervisor and telemetry averager of a step-down converter.
 Assumes host settings, ADC and PWM strobes come from logic on sys_clk;
 only the thermal shutdown comparator is asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
module cfs_supervisor import cfs_pkg::*; #(
	parameter int DW          = 12,
	parameter int OCW         = 4,
	parameter int CONV_CYCLES = CONV_CYC
) (
	input  wire logic          sys_clk,
	input  wire logic          rst_b,
	input  wire logic [2:0]    avgLog2,
	output logic               adcStart,
	output logic [1:0]         adcSel,
	input  wire logic          adcDone,
	input  wire logic [DW-1:0] adcData,
	input  wire logic          lsSampleValid,
	input  wire logic [DW-1:0] lsCurFirst,
	input  wire logic [DW-1:0] lsCurLast,
	input  wire logic          cycleStart,
	input  wire logic [DW-1:0] hsPeakCur,
	input  wire logic [DW-1:0] ocWarnLimit,
	input  wire logic [DW-1:0] ocFaultLimit,
	input  wire logic [2:0]    ocDelay,
	input  wire logic [1:0]    ocResp,
	input  wire logic [DW-1:0] ovFaultLimit,
	input  wire logic [DW-1:0] ovWarnLimit,
	input  wire logic [DW-1:0] uvWarnLimit,
	input  wire logic [DW-1:0] uvFaultLimit,
	input  wire logic [1:0]    ovResp,
	input  wire logic [1:0]    uvResp,
	input  wire logic [2:0]    uvDelay,
	input  wire logic [7:0]    voutScale,
	input  wire logic [DW-1:0] otWarnLimit,
	input  wire logic [DW-1:0] otFaultLimit,
	input  wire logic [1:0]    otResp,
	input  wire logic          tsdPin,
	input  wire logic          tsdDisable,
	input  wire logic          outRising,
	input  wire logic          clearFaults,
	input  wire logic          restartGo,
	input  wire logic [7:0]    alertMask,
	output logic [DW-1:0]      telVin,
	output logic [DW-1:0]      telVout,
	output logic [DW-1:0]      telIout,
	output logic [DW-1:0]      telTemp,
	output logic               hsPulseEnd,
	output logic               lsForceOn,
	output logic               convOff,
	output logic               restartReq,
	output logic               powerGood,
	output logic               alert,
	output logic [7:0]         faultStatus
);
	localparam int CW = $clog2(CONV_CYCLES + 1);

	typedef struct packed {
		cfs_state_t               st;
		logic [1:0]               tsdSync;
		logic [3:0][15:0][DW-1:0] hist;
		logic [3:0][DW+3:0]       sum;
		logic [3:0][3:0]          ptr;
		logic [3:0][DW-1:0]       raw;
		logic [3:0][DW-1:0]       tel;
		logic [2:0]               avgLast;
		logic [DW-1:0]            iMean;
		logic                     hsSeen;
		logic                     hsEnd;
		logic                     contActive;
		logic                     ovRestart;
		logic [OCW-1:0]           ocCnt;
		logic [OCW-1:0]           uvCnt;
		logic                     adcBusy;
		logic                     adcStart;
		logic [1:0]               adcSel;
		logic [CW-1:0]            convCnt;
		logic                     convOff;
		logic                     lsOn;
		logic                     restartReq;
		logic                     power_good_output;
		logic                     alert;
		logic [7:0]               status;
	} cfs_regs_t;

	cfs_regs_t s;
	cfs_regs_t next_s;
	logic [1:0] rstSync;
	logic       rstN;

	function automatic logic isShut(input logic [1:0] r);
		return r == RESP_SHUT;
	endfunction
	function automatic logic isRst(input logic [1:0] r);
		return r == RESP_RESTART;
	endfunction
	// Codes above restart all mean continue operating
	function automatic logic isIgn(input logic [1:0] r);
		return r[1];
	endfunction

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rstSync <= 2'h0;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstN = rstSync[1];

	logic [DW:0]    hsLim;
	logic           hsTrip, ocHit, ocF, ovF, uvLow, uvF, otF, otW, tsdF;
	logic           shutAny, rstAny, contAny, dischDone;
	logic [DW+7:0]  voutProd;
	assign hsLim     = {1'b0, ocFaultLimit} + (DW+1)'(ocFaultLimit >> 1);
	assign hsTrip    = {1'b0, hsPeakCur} > hsLim;
	assign ocHit     = (s.iMean > ocFaultLimit) | s.hsSeen;
	assign ocF       = s.ocCnt > OCW'(ocDelay);
	assign ovF       = s.raw[Q_VOUT] > ovFaultLimit;
	assign uvLow     = (s.raw[Q_VOUT] < uvFaultLimit) & ~outRising;
	assign uvF       = s.uvCnt > OCW'(uvDelay);
	assign otF       = s.raw[Q_TEMP] > otFaultLimit;
	assign otW       = s.raw[Q_TEMP] > otWarnLimit;
	assign tsdF      = s.tsdSync[1] & ~tsdDisable;
	assign voutProd  = s.raw[Q_VOUT] * voutScale;
	assign dischDone = int'(voutProd[DW+7:SCALE_FRAC]) <= DISCH_CODE;
	assign shutAny = (ocF & isShut(ocResp)) | (uvF & isShut(uvResp))
		| ((otF | tsdF) & isShut(otResp));
	assign rstAny  = (ocF & isRst(ocResp)) | (uvF & isRst(uvResp))
		| ((otF | tsdF) & isRst(otResp));
	assign contAny = (ocF & isIgn(ocResp)) | (uvF & isIgn(uvResp))
		| (ovF & isIgn(ovResp)) | ((otF | tsdF) & isIgn(otResp));

	always_comb begin
		logic           newValid;
		logic [DW-1:0]  newVal;
		logic [1:0]     q;
		logic [2:0]     lg;
		logic [3:0]     win, old;
		logic [DW+3:0]  nsum;
		logic [7:0]     ev;
		newValid = 1'b0;
		newVal   = s.iMean;
		q        = s.adcSel;
		lg       = (avgLog2 > AVG_MAX_LOG2) ? AVG_MAX_LOG2 : avgLog2;
		win      = 4'((5'h01) << lg);
		old      = s.ptr[q] - win;
		nsum     = '0;
		ev       = 8'h00;
		next_s   = s;
		next_s.tsdSync  = {s.tsdSync[0], tsdPin};
		next_s.adcStart = 1'b0;
		next_s.hsEnd    = hsTrip;
		next_s.hsSeen   = hsTrip | (s.hsSeen & ~cycleStart);
		if (lsSampleValid) begin
			next_s.iMean = DW'(({1'b0, lsCurFirst} + {1'b0, lsCurLast}) >> 1);
		end
		// Round robin over four slots keeps every value under the refresh bound
		if (!s.adcBusy) begin
			if (s.adcSel == Q_IOUT) begin
				newValid      = 1'b1;
				next_s.adcSel = s.adcSel + 2'h1;
			end else begin
				next_s.adcStart = 1'b1;
				next_s.adcBusy  = 1'b1;
				next_s.convCnt  = '0;
			end
		end else if (adcDone) begin
			newValid       = 1'b1;
			newVal         = adcData;
			next_s.adcBusy = 1'b0;
			next_s.adcSel  = s.adcSel + 2'h1;
		end else if (s.convCnt == CW'(CONV_CYCLES - 1)) begin
			next_s.adcBusy = 1'b0;
			next_s.adcSel  = s.adcSel + 2'h1;
			ev[ST_CTO]     = 1'b1;
		end else begin
			next_s.convCnt = s.convCnt + CW'(1);
		end
		// Window change flushes history so no stale sample enters the sum
		if (lg != s.avgLast) begin
			next_s.avgLast = lg;
			next_s.hist    = '0;
			next_s.sum     = '0;
			next_s.ptr     = '0;
		end else if (newValid) begin
			nsum = s.sum[q] + (DW+4)'(newVal) - (DW+4)'(s.hist[q][old]);
			next_s.sum[q]           = nsum;
			next_s.hist[q][s.ptr[q]] = newVal;
			next_s.ptr[q]           = s.ptr[q] + 4'h1;
			next_s.tel[q]           = DW'(nsum >> lg);
		end
		if (newValid) begin
			next_s.raw[q] = newVal;
		end
		if (cycleStart && s.st == CFS_RUN) begin
			if (ocHit) begin
				if (s.ocCnt != '1) next_s.ocCnt = s.ocCnt + OCW'(1);
			end else if (s.ocCnt != '0) begin
				next_s.ocCnt = s.ocCnt - OCW'(1);
			end
			if (!uvLow) begin
				next_s.uvCnt = '0;
			end else if (s.uvCnt != '1) begin
				next_s.uvCnt = s.uvCnt + OCW'(1);
			end
			ev[ST_OCW] = s.iMean > ocWarnLimit;
		end
		ev[ST_OCF] = ocF;
		ev[ST_OVF] = ovF;
		ev[ST_UVF] = uvF;
		ev[ST_OTW] = otW;
		ev[ST_OTF] = otF;
		ev[ST_TSD] = tsdF;
		if (clearFaults) next_s.contActive = 1'b0;
		case (s.st)
			CFS_RUN: begin
				if (ovF && !isIgn(ovResp)) begin
					next_s.st        = CFS_DISCH;
					next_s.ovRestart = isRst(ovResp) & ~s.contActive;
				end else if (shutAny) begin
					next_s.st = CFS_OFF;
				end else if (rstAny) begin
					next_s.st = s.contActive ? CFS_OFF : CFS_RESTART;
				end
				if (contAny) next_s.contActive = 1'b1;
			end
			CFS_DISCH: begin
				if (dischDone) next_s.st = s.ovRestart ? CFS_RESTART : CFS_OFF;
			end
			CFS_RESTART: begin
				if (restartGo) begin
					next_s.st         = CFS_RUN;
					next_s.ocCnt      = '0;
					next_s.uvCnt      = '0;
					next_s.contActive = 1'b0;
				end
			end
			default: begin
				if (clearFaults) begin
					next_s.st         = CFS_RUN;
					next_s.ocCnt      = '0;
					next_s.uvCnt      = '0;
					next_s.contActive = 1'b0;
				end
			end
		endcase
		next_s.convOff    = next_s.st != CFS_RUN;
		next_s.lsOn       = next_s.st == CFS_DISCH;
		next_s.restartReq = next_s.st == CFS_RESTART;
		next_s.power_good_output      = (next_s.st == CFS_RUN) & ~outRising
			& (s.raw[Q_VOUT] > uvWarnLimit) & (s.raw[Q_VOUT] < ovWarnLimit);
		// Set wins over a clear in the same cycle
		next_s.status     = (s.status & ~{8{clearFaults}}) | ev;
		next_s.alert      = |(next_s.status & ~alertMask);
	end

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign adcStart    = s.adcStart;
	assign adcSel      = s.adcSel;
	assign telVin      = s.tel[Q_VIN];
	assign telVout     = s.tel[Q_VOUT];
	assign telIout     = s.tel[Q_IOUT];
	assign telTemp     = s.tel[Q_TEMP];
	assign hsPulseEnd  = s.hsEnd;
	assign lsForceOn   = s.lsOn;
	assign convOff     = s.convOff;
	assign restartReq  = s.restartReq;
	assign powerGood   = s.power_good_output;
	assign alert       = s.alert;
	assign faultStatus = s.status;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstN);

	chk_hs_term: assert property (hsTrip |=> hsPulseEnd)
		else $error("high-side pulse not ended");
	chk_oc_inc: assert property (
		cycleStart && s.st == CFS_RUN && ocHit && s.ocCnt != '1
		|=> s.ocCnt == $past(s.ocCnt) + OCW'(1))
		else $error("event counter did not count up");
	chk_oc_dec: assert property (
		cycleStart && s.st == CFS_RUN && !ocHit
		|=> s.ocCnt == (($past(s.ocCnt) == '0) ? '0 : $past(s.ocCnt) - OCW'(1)))
		else $error("event counter did not count down");
	// A clear in the first OFF cycle legally reopens the output
	chk_oc_shut: assert property (
		(s.st == CFS_RUN && ocF && isShut(ocResp) && !ovF ##1 !clearFaults)
		|-> (convOff && !restartReq) ##1 (convOff && !restartReq))
		else $error("overcurrent fault did not shut down");
	chk_ov_disch: assert property (
		s.st == CFS_RUN && ovF && !isIgn(ovResp)
		|=> lsForceOn && convOff)
		else $error("overvoltage discharge not started");
	chk_disch_end: assert property (
		s.st == CFS_DISCH && dischDone
		|=> !lsForceOn && convOff)
		else $error("discharge did not end");
	chk_mean_calc: assert property (
		lsSampleValid |=> s.iMean
		== DW'(({1'b0, $past(lsCurFirst)} + {1'b0, $past(lsCurLast)}) >> 1))
		else $error("current mean wrong");
	chk_otw_alert: assert property (
		otW && !alertMask[ST_OTW] |=> alert && faultStatus[ST_OTW])
		else $error("temperature warning not alerted");
	chk_tsd_off: assert property (
		s.st == CFS_RUN && tsdF && !isIgn(otResp)
		|=> convOff)
		else $error("thermal shutdown ignored");
	chk_prio_shut: assert property (
		s.st == CFS_RUN && shutAny && !(ovF && !isIgn(ovResp))
		|=> s.st == CFS_OFF)
		else $error("shutdown lost priority");
	chk_conv_bound: assert property (s.adcBusy |-> s.convCnt < CW'(CONV_CYCLES))
		else $error("conversion overran");

	cov_oc_fault: cover property (s.st == CFS_RUN ##1 convOff && faultStatus[ST_OCF]);
	cov_ov_disch: cover property (lsForceOn ##1 !lsForceOn && restartReq);
	cov_restart: cover property (restartReq ##1 !convOff);
	cov_otw_pg: cover property (alert && powerGood && faultStatus[ST_OTW]);
endmodule // cfs_supervisor
`default_nettype wire

// file: cfs_adc_model.sv
/*
 Behavioural converter on the far side of the telemetry sequencer.
 Assumes one start pulse per slot; a fresh start restarts a conversion.
*/
`timescale 1ns/10ps
`default_nettype none
module cfs_adc_model import cfs_pkg::*; #(
	parameter int DW = 12
) (
	input  wire logic          sys_clk,
	input  wire logic          rst_b,
	input  wire logic          adcStart,
	input  wire logic [1:0]    adcSel,
	input  wire logic [7:0]    latency,
	input  wire logic [DW-1:0] vin,
	input  wire logic [DW-1:0] vout,
	input  wire logic [DW-1:0] temp,
	output logic               adcDone,
	output logic [DW-1:0]      adcData
);
	logic          busy;
	logic          flip;
	logic [1:0]    slot;
	logic [7:0]    cnt;
	logic [DW-1:0] value;
	// Input voltage alternates, so only a true average is steady
	always_comb begin
		case (slot)
			Q_VIN:   value = flip ? vin + DW'(16) : vin - DW'(16);
			Q_VOUT:  value = vout;
			default: value = temp;
		endcase
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy    <= 1'b0;
			flip    <= 1'b0;
			slot    <= 2'h0;
			cnt     <= 8'h00;
			adcDone <= 1'b0;
			adcData <= '0;
		end else begin
			adcDone <= 1'b0;
			// Idle data bus toggles so stale values never look valid
			adcData <= ~adcData;
			if (adcStart) begin
				busy <= 1'b1;
				slot <= adcSel;
				cnt  <= latency;
			end else if (busy && cnt == 8'h00) begin
				busy    <= 1'b0;
				adcDone <= 1'b1;
				adcData <= value;
				flip    <= flip ^ (slot == Q_VIN);
			end else if (busy) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule // cfs_adc_model
`default_nettype wire

// file: testbench.sv
/*
 Self-checking bench for the converter fault supervisor.
 Assumes the behavioural converter model and a shortened conversion timeout.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench import cfs_pkg::*; ;
	localparam int DW = 12;
	logic sys_clk = 1'b0, rst_b = 1'b0, lsSampleValid = 1'b0, cycleStart = 1'b0;
	logic tsdPin = 1'b0, tsdDisable = 1'b0, outRising = 1'b0, clearFaults = 1'b0;
	logic restartGo = 1'b0, adcStart, adcDone, hsPulseEnd, lsForceOn, convOff;
	logic restartReq, powerGood, alert, pe;
	logic [2:0] avgLog2 = 3'h4, ocDelay = 3'h3, uvDelay = 3'h2;
	logic [1:0] adcSel, ocResp = 2'h0, ovResp = 2'h1, uvResp = 2'h0, otResp = 2'h0;
	logic [7:0] voutScale = 8'h80, alertMask = 8'h00, latency = 8'h03, faultStatus;
	logic [DW-1:0] ocWarnLimit = 12'h080, ocFaultLimit = 12'h100, hsPeakCur = 12'h000;
	logic [DW-1:0] ovFaultLimit = 12'h600, ovWarnLimit = 12'h500, uvWarnLimit = 12'h300;
	logic [DW-1:0] uvFaultLimit = 12'h100, otWarnLimit = 12'h100, otFaultLimit = 12'h200;
	logic [DW-1:0] vin = 12'h300, vout = 12'h400, temp = 12'h050, adcData;
	logic [DW-1:0] lsCurFirst = 12'h000, lsCurLast = 12'h000, telVin, telVout, telIout, telTemp;
	logic [31:0] lfsr = 32'hDE0D1F43;
	int errorCnt = 0, comparisons = 0, i;

	cfs_supervisor #(.DW(DW), .CONV_CYCLES(20)) i_dut (.*);
	cfs_adc_model #(.DW(DW)) i_adc (.*);

	initial begin
		forever #10 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] nextRand(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction
	function automatic logic expEnd(input logic [DW-1:0] pk, input logic [DW-1:0] lim);
		return {1'b0, pk} > ({1'b0, lim} + {2'b00, lim[DW-1:1]});
	endfunction

	task automatic chkv(input logic [DW-1:0] got, input logic [DW-1:0] exp);
		comparisons++;
		if (got !== exp) begin
			errorCnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		chkv(DW'(got), DW'(exp));
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic ocCycle(input logic [DW-1:0] cur);
		lsCurFirst = cur;
		lsCurLast = cur;
		lsSampleValid = 1'b1;
		cyc(1);
		lsSampleValid = 1'b0;
		cycleStart = 1'b1;
		cyc(1);
		cycleStart = 1'b0;
		cyc(3);
	endtask
	task automatic clr();
		clearFaults = 1'b1;
		cyc(1);
		clearFaults = 1'b0;
		cyc(2);
	endtask
	task automatic go();
		restartGo = 1'b1;
		cyc(1);
		restartGo = 1'b0;
		cyc(2);
	endtask
	task automatic results();
		if (errorCnt == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Whole run is under two thousand cycles; generous margin
	initial begin
		#400000;
		errorCnt++;
		results();
	end

	initial begin
		cyc(4);
		rst_b = 1'b1;
		cyc(3);
		lsCurFirst = 12'h020;
		lsCurLast = 12'h031;
		lsSampleValid = 1'b1;
		cyc(1);
		lsSampleValid = 1'b0;
		cyc(500);
		chkv(telVin, 12'h300);
		chkv(telVout, 12'h400);
		chkv(telIout, 12'h028);
		chkv(telTemp, 12'h050);
		chkb(faultStatus[7], 1'b0);
		chkb(powerGood, 1'b1);
		// Random limits and peaks, exact threshold corners first
		for (i = 0; i < 24; i++) begin
			lfsr = nextRand(lfsr);
			ocFaultLimit = (i < 2) ? 12'h100 : lfsr[11:0];
			hsPeakCur = (i < 2) ? 12'h180 + DW'(i) : lfsr[23:12];
			pe = expEnd(hsPeakCur, ocFaultLimit);
			cyc(1);
			chkb(hsPulseEnd, pe);
		end
		hsPeakCur = 12'h000;
		ocFaultLimit = 12'h100;
		latency = 8'h20;
		cyc(80);
		chkb(faultStatus[7], 1'b1);
		latency = 8'h03;
		// Let a slow conversion still in flight time out before the clear
		cyc(40);
		clr();
		for (i = 0; i < 3; i++) begin
			otResp = (i == 2) ? 2'h3 : 2'(i);
			temp = 12'h250;
			cyc(60);
			chkb(convOff, i != 2);
			chkb(restartReq, i == 1);
			chkb(faultStatus[5], 1'b1);
			temp = 12'h050;
			cyc(60);
			if (i == 1) go();
			clr();
		end
		otResp = 2'h0;
		temp = 12'h150;
		outRising = 1'b1;
		cyc(60);
		chkb(alert, 1'b1);
		chkb(convOff, 1'b0);
		outRising = 1'b0;
		alertMask = 8'h10;
		cyc(3);
		chkb(alert, 1'b0);
		chkb(powerGood, 1'b1);
		temp = 12'h050;
		alertMask = 8'h00;
		cyc(60);
		clr();
		tsdPin = 1'b1;
		tsdDisable = 1'b1;
		cyc(10);
		chkb(convOff, 1'b0);
		tsdDisable = 1'b0;
		cyc(10);
		chkb(convOff, 1'b1);
		chkb(faultStatus[6], 1'b1);
		tsdPin = 1'b0;
		cyc(4);
		clr();
		repeat (3) ocCycle(12'h300);
		ocCycle(12'h010);
		ocCycle(12'h300);
		chkb(convOff, 1'b0);
		repeat (6) ocCycle(12'h010);
		repeat (3) ocCycle(12'h300);
		chkb(convOff, 1'b0);
		ocCycle(12'h300);
		chkb(convOff, 1'b1);
		chkb(powerGood, 1'b0);
		chkb(faultStatus[0], 1'b1);
		chkb(faultStatus[1], 1'b1);
		clr();
		repeat (6) ocCycle(12'h010);
		ocResp = 2'h1;
		repeat (4) ocCycle(12'h300);
		chkb(restartReq, 1'b1);
		go();
		repeat (6) ocCycle(12'h010);
		ocResp = 2'h2;
		repeat (4) ocCycle(12'h300);
		chkb(convOff, 1'b0);
		otResp = 2'h1;
		temp = 12'h250;
		cyc(60);
		chkb(convOff, 1'b1);
		chkb(restartReq, 1'b0);
		temp = 12'h050;
		cyc(60);
		clr();
		repeat (6) ocCycle(12'h010);
		vout = 12'h700;
		cyc(60);
		chkb(lsForceOn, 1'b1);
		vout = 12'h192;
		cyc(60);
		chkb(lsForceOn, 1'b1);
		vout = 12'h190;
		cyc(60);
		chkb(lsForceOn, 1'b0);
		chkb(restartReq, 1'b1);
		vout = 12'h400;
		go();
		cyc(60);
		chkb(powerGood, 1'b1);
		ovResp = 2'h3;
		vout = 12'h700;
		cyc(60);
		chkb(lsForceOn, 1'b0);
		chkb(faultStatus[2], 1'b1);
		vout = 12'h080;
		outRising = 1'b1;
		cyc(60);
		clr();
		repeat (4) ocCycle(12'h010);
		chkb(faultStatus[3], 1'b0);
		outRising = 1'b0;
		cyc(2);
		ocCycle(12'h010);
		chkb(convOff, 1'b0);
		repeat (3) ocCycle(12'h010);
		chkb(convOff, 1'b1);
		chkb(faultStatus[3], 1'b1);
		results();
	end
endmodule // testbench
`default_nettype wire
